// ### shared/spac_pkg.sv
package spac_pkg;

    // register offsets, byte addressed on an 8-bit port
    localparam logic [7:0] ADDR_SYNC_CFG   = 8'h35;
    localparam logic [7:0] ADDR_SLOT_CFG   = 8'h36;
    localparam logic [7:0] ADDR_MOTION_CTL = 8'h37;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h41;

    localparam logic [7:0] RESET_CFG       = 8'h00;
    localparam logic [7:0] SYNC_CFG_WMASK  = 8'h7F;

    // sync_clock_source_config fields
    localparam int SYNC_SOURCE_SELECT_BIT      = 6;
    localparam int SYNC_MODE_LSB     = 4;
    localparam int BIT_CLK_SRC_LSB   = 2;
    localparam int FRAME_CLK_SRC_LSB = 0;

    // pulse_density_slot_routing fields
    localparam int FRAME_SLOT_B_LSB = 6;
    localparam int FRAME_SLOT_A_LSB = 4;
    localparam int OUT0_SLOT_B_LSB  = 2;
    localparam int OUT0_SLOT_A_LSB  = 0;

    // motion_detect_and_polarity_control fields
    localparam int PDM_POLARITY_INVERT_BIT      = 7;
    localparam int HPF_EN_BIT       = 6;
    localparam int CHAIN_MODE_LSB   = 4;
    localparam int INACTIVITY_DETECT_ENABLE_LSB     = 2;
    localparam int ACT_EN_LSB       = 0;

    // interrupt status / mask bits
    localparam int IRQ_ACT_BIT   = 0;
    localparam int IRQ_INACT_BIT = 1;

    localparam logic [1:0] SYNC_NONE   = 2'h0;
    localparam logic [1:0] SYNC_LOCK   = 2'h1;
    localparam logic [1:0] SYNC_INTERP = 2'h2;

    localparam logic [1:0] CLK_EXTERNAL = 2'h0;
    localparam logic [1:0] CLK_INT_A    = 2'h1;
    localparam logic [1:0] CLK_INT_B    = 2'h2;

    localparam logic [1:0] SLOT_ZERO = 2'h0;
    localparam logic [1:0] SLOT_X    = 2'h1;
    localparam logic [1:0] SLOT_Y    = 2'h2;
    localparam logic [1:0] SLOT_Z    = 2'h3;

    localparam logic [1:0] CHAIN_INDEP  = 2'h0;
    localparam logic [1:0] CHAIN_LINKED = 2'h1;
    localparam logic [1:0] CHAIN_INDEP2 = 2'h2;
    localparam logic [1:0] CHAIN_LOOPED = 2'h3;

    localparam logic [1:0] DET_ABSOLUTE   = 2'h1;
    localparam logic [1:0] DET_REFERENCED = 2'h3;

    // internal clock rates
    localparam longint CLK_HZ             = 20_000_000;
    localparam longint BIT_CLK_FAST_KHZ   = 1024;
    localparam longint BIT_CLK_SLOW_KHZ   = 512;
    localparam longint FRAME_CLK_SLOW_KHZ = 16;
    localparam longint FRAME_CLK_FAST_KHZ = 32;
    localparam int     NCO_W              = 24;

    function automatic logic [NCO_W-1:0] spac_nco_inc(input longint khz);
        return NCO_W'((khz * 64'd1000 * (64'd1 << NCO_W)) / CLK_HZ);
    endfunction : spac_nco_inc

    localparam logic [NCO_W-1:0] INC_BIT_FAST   = spac_nco_inc(BIT_CLK_FAST_KHZ);
    localparam logic [NCO_W-1:0] INC_BIT_SLOW   = spac_nco_inc(BIT_CLK_SLOW_KHZ);
    localparam logic [NCO_W-1:0] INC_FRAME_SLOW = spac_nco_inc(FRAME_CLK_SLOW_KHZ);
    localparam logic [NCO_W-1:0] INC_FRAME_FAST = spac_nco_inc(FRAME_CLK_FAST_KHZ);

    localparam int SAMPLE_W = 12;

    typedef enum logic [0:0] {WAIT_ACT, WAIT_INACT} spac_seq_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } spac_bus_req_t;

    typedef struct packed {
        logic                x;
        logic                y;
        logic                z;
    } spac_pdm_bits_t;

    typedef struct packed {
        logic [7:0]          syncCfg;
        logic [7:0]          slotCfg;
        logic [7:0]          motionCtl;
        logic [1:0]          status;
        logic [1:0]          mask;
        logic [7:0]          rdata;
        logic                frameS1;
        logic                frameS2;
        logic                intS1;
        logic                intS2;
        logic                bclkS1;
        logic                bclkS2;
        logic                syncPrev;
        logic                bitPrev;
        logic                framePrev;
        logic [NCO_W-1:0]    bitAcc;
        logic [NCO_W-1:0]    frameAcc;
        logic                bitClk;
        logic                frameClk;
        logic                odrStrobe;
        logic                interpStrobe;
        logic                dsmLocked;
        logic                pdmFrameOut;
        logic                pdmOut0;
        logic [SAMPLE_W-1:0] detSample;
        logic                detValid;
        logic                actDetect;
        logic                inactDetect;
        spac_seq_t           seq;
        logic                actClkEn;
        logic                irq;
    } spac_state_t;

endpackage : spac_pkg

// ### src/spac_config_bank.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module spac_config_bank
    import spac_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire spac_bus_req_t       busReq,
    output var  logic [7:0]          regRdata,
    input  wire logic                framePinIn,
    input  wire logic                intOnePinIn,
    input  wire logic                extBitClkIn,
    input  wire spac_pdm_bits_t      pdmBits,
    input  wire logic                sarValid,
    input  wire logic [SAMPLE_W-1:0] sarSample,
    input  wire logic [SAMPLE_W-1:0] hpfSample,
    input  wire logic                actHit,
    input  wire logic                inactHit,
    output var  logic                bitClkOut,
    output var  logic                frameClkOut,
    output var  logic                odrStrobe,
    output var  logic                interpStrobe,
    output var  logic                dsmLocked,
    output var  logic                pdmFramePinOut,
    output var  logic                pdmOut0,
    output var  logic [SAMPLE_W-1:0] detSample,
    output var  logic                detValid,
    output var  logic [1:0]          actMode,
    output var  logic [1:0]          inactMode,
    output var  logic                actClkEn,
    output var  logic                actDetect,
    output var  logic                inactDetect,
    output var  logic                irq
);

    spac_state_t st_reg;
    spac_state_t st_next;

    function automatic logic slot_bit(input logic [1:0] code, input spac_pdm_bits_t b,
                                      input logic pol);
        logic v;
        v = 1'b0;
        case (code)
            SLOT_X:  v = b.x ^ pol;
            SLOT_Y:  v = b.y ^ pol;
            SLOT_Z:  v = b.z ^ pol;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : slot_bit

    function automatic logic det_on(input logic [1:0] code);
        return (code == DET_ABSOLUTE) || (code == DET_REFERENCED);
    endfunction : det_on

    logic       selSync;
    logic       syncRise;
    logic       bitRise;
    logic       bitFall;
    logic       frameRise;
    logic [1:0] syncMode;
    logic [1:0] bitSrc;
    logic [1:0] frameSrc;
    logic [1:0] chain;
    logic       pol;
    logic       actOk;
    logic       inactOk;
    logic [1:0] setEv;
    logic [1:0] clrEv;

    always_comb begin
        st_next  = st_reg;
        syncMode = st_reg.syncCfg[SYNC_MODE_LSB +: 2];
        bitSrc   = st_reg.syncCfg[BIT_CLK_SRC_LSB +: 2];
        frameSrc = st_reg.syncCfg[FRAME_CLK_SRC_LSB +: 2];
        chain    = st_reg.motionCtl[CHAIN_MODE_LSB +: 2];
        pol      = st_reg.motionCtl[PDM_POLARITY_INVERT_BIT];

        st_next.frameS1 = framePinIn;
        st_next.frameS2 = st_reg.frameS1;
        st_next.intS1   = intOnePinIn;
        st_next.intS2   = st_reg.intS1;
        st_next.bclkS1  = extBitClkIn;
        st_next.bclkS2  = st_reg.bclkS1;

        selSync          = st_reg.syncCfg[SYNC_SOURCE_SELECT_BIT] ? st_reg.intS2 : st_reg.frameS2;
        st_next.syncPrev = selSync;
        syncRise         = selSync & ~st_reg.syncPrev;

        // nco clocks average the right rate but jitter by one system clock
        case (bitSrc)
            CLK_INT_A: begin
                st_next.bitAcc = st_reg.bitAcc + INC_BIT_FAST;
                st_next.bitClk = st_reg.bitAcc[NCO_W-1];
            end
            CLK_INT_B: begin
                st_next.bitAcc = st_reg.bitAcc + INC_BIT_SLOW;
                st_next.bitClk = st_reg.bitAcc[NCO_W-1];
            end
            default: begin
                st_next.bitAcc = '0;
                st_next.bitClk = st_reg.bclkS2;
            end
        endcase
        case (frameSrc)
            CLK_INT_A: begin
                st_next.frameAcc = st_reg.frameAcc + INC_FRAME_SLOW;
                st_next.frameClk = st_reg.frameAcc[NCO_W-1];
            end
            CLK_INT_B: begin
                st_next.frameAcc = st_reg.frameAcc + INC_FRAME_FAST;
                st_next.frameClk = st_reg.frameAcc[NCO_W-1];
            end
            default: begin
                st_next.frameAcc = '0;
                st_next.frameClk = st_reg.frameS2;
            end
        endcase
        st_next.bitPrev   = st_reg.bitClk;
        st_next.framePrev = st_reg.frameClk;
        bitRise   = st_reg.bitClk & ~st_reg.bitPrev;
        bitFall   = ~st_reg.bitClk & st_reg.bitPrev;
        frameRise = st_reg.frameClk & ~st_reg.framePrev;

        // free-running paths take their data rate from the frame clock
        st_next.dsmLocked    = (syncMode == SYNC_LOCK);
        st_next.odrStrobe    = (syncMode == SYNC_LOCK) ? syncRise : frameRise;
        st_next.interpStrobe = (syncMode == SYNC_INTERP) && syncRise;

        // slot a on the high phase, slot b on the low phase of the bit clock
        if (bitRise) begin
            st_next.pdmOut0     = slot_bit(st_reg.slotCfg[OUT0_SLOT_A_LSB +: 2], pdmBits, pol);
            st_next.pdmFrameOut = slot_bit(st_reg.slotCfg[FRAME_SLOT_A_LSB +: 2], pdmBits, pol);
        end else if (bitFall) begin
            st_next.pdmOut0     = slot_bit(st_reg.slotCfg[OUT0_SLOT_B_LSB +: 2], pdmBits, pol);
            st_next.pdmFrameOut = slot_bit(st_reg.slotCfg[FRAME_SLOT_B_LSB +: 2], pdmBits, pol);
        end

        st_next.detValid = sarValid;
        if (sarValid) begin
            st_next.detSample = st_reg.motionCtl[HPF_EN_BIT] ? hpfSample : sarSample;
        end

        st_next.actClkEn = det_on(st_reg.motionCtl[ACT_EN_LSB +: 2]);
        actOk   = actHit && det_on(st_reg.motionCtl[ACT_EN_LSB +: 2]);
        inactOk = inactHit && det_on(st_reg.motionCtl[INACTIVITY_DETECT_ENABLE_LSB +: 2]);
        // linked and looped modes rely on the host enabling both detectors first
        case (chain)
            CHAIN_LINKED: begin
                actOk   = actOk && (st_reg.seq == WAIT_ACT) && !st_reg.status[IRQ_INACT_BIT];
                inactOk = inactOk && (st_reg.seq == WAIT_INACT) && !st_reg.status[IRQ_ACT_BIT];
            end
            CHAIN_LOOPED: begin
                actOk   = actOk && (st_reg.seq == WAIT_ACT);
                inactOk = inactOk && (st_reg.seq == WAIT_INACT);
            end
            default: begin
                actOk   = actOk && !st_reg.status[IRQ_ACT_BIT];
                inactOk = inactOk && !st_reg.status[IRQ_INACT_BIT];
            end
        endcase
        if (actOk) begin
            st_next.seq = WAIT_INACT;
        end else if (inactOk) begin
            st_next.seq = WAIT_ACT;
        end
        st_next.actDetect   = actOk;
        st_next.inactDetect = inactOk;

        st_next.rdata = '0;
        if (busReq.rd) begin
            case (busReq.addr)
                ADDR_SYNC_CFG:   st_next.rdata = st_reg.syncCfg;
                ADDR_SLOT_CFG:   st_next.rdata = st_reg.slotCfg;
                ADDR_MOTION_CTL: st_next.rdata = st_reg.motionCtl;
                ADDR_IRQ_STATUS: st_next.rdata = {6'h00, st_reg.status};
                ADDR_IRQ_MASK:   st_next.rdata = {6'h00, st_reg.mask};
                default:         st_next.rdata = '0;
            endcase
        end
        clrEv = '0;
        if (busReq.wr) begin
            case (busReq.addr)
                ADDR_SYNC_CFG:   st_next.syncCfg = busReq.wdata & SYNC_CFG_WMASK;
                ADDR_SLOT_CFG:   st_next.slotCfg = busReq.wdata;
                ADDR_MOTION_CTL: st_next.motionCtl = busReq.wdata;
                ADDR_IRQ_STATUS: clrEv = busReq.wdata[1:0];
                ADDR_IRQ_MASK:   st_next.mask = busReq.wdata[1:0];
                default:         clrEv = '0;
            endcase
        end
        // a detection in the clearing cycle survives the clear
        setEv          = {inactOk, actOk};
        st_next.status = (st_reg.status & ~clrEv) | setEv;
        st_next.irq    = |(st_next.status & st_next.mask);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regRdata       = st_reg.rdata;
    assign bitClkOut      = st_reg.bitClk;
    assign frameClkOut    = st_reg.frameClk;
    assign odrStrobe      = st_reg.odrStrobe;
    assign interpStrobe   = st_reg.interpStrobe;
    assign dsmLocked      = st_reg.dsmLocked;
    assign pdmFramePinOut = st_reg.pdmFrameOut;
    assign pdmOut0        = st_reg.pdmOut0;
    assign detSample      = st_reg.detSample;
    assign detValid       = st_reg.detValid;
    assign actMode        = st_reg.motionCtl[ACT_EN_LSB +: 2];
    assign inactMode      = st_reg.motionCtl[INACTIVITY_DETECT_ENABLE_LSB +: 2];
    assign actClkEn       = st_reg.actClkEn;
    assign actDetect      = st_reg.actDetect;
    assign inactDetect    = st_reg.inactDetect;
    assign irq            = st_reg.irq;

    property p_reset_zero;
        @(posedge clk) $rose(resetn) |-> (st_reg.syncCfg == RESET_CFG)
            && (st_reg.slotCfg == RESET_CFG) && (st_reg.motionCtl == RESET_CFG);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("config register not zero after reset");

    property p_sync_source_select;
        @(posedge clk) disable iff (!resetn)
        (st_reg.syncCfg[SYNC_MODE_LSB +: 2] == SYNC_LOCK) && st_reg.syncCfg[SYNC_SOURCE_SELECT_BIT]
            && st_reg.intS2 && !st_reg.syncPrev |=> odrStrobe;
    endproperty
    a_sync_source_select: assert property (p_sync_source_select)
        else $error("interrupt-one sync edge did not strobe data rate");

    property p_free_run;
        @(posedge clk) disable iff (!resetn)
        (st_reg.syncCfg[SYNC_MODE_LSB +: 2] != SYNC_LOCK) |=> !dsmLocked;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("path locked while sync mode is not lock");

    property p_interp;
        @(posedge clk) disable iff (!resetn)
        interpStrobe |-> $past(st_reg.syncCfg[SYNC_MODE_LSB +: 2]) == SYNC_INTERP;
    endproperty
    a_interp: assert property (p_interp)
        else $error("interpolation strobe outside interpolation mode");

    property p_bit_ext;
        @(posedge clk) disable iff (!resetn)
        (st_reg.syncCfg[BIT_CLK_SRC_LSB +: 2] == CLK_EXTERNAL) ##1
        (st_reg.syncCfg[BIT_CLK_SRC_LSB +: 2] == CLK_EXTERNAL)
            |-> bitClkOut == $past(st_reg.bclkS2);
    endproperty
    a_bit_ext: assert property (p_bit_ext)
        else $error("external bit clock not followed");

    property p_slot_zero;
        @(posedge clk) disable iff (!resetn)
        st_reg.bitClk && !st_reg.bitPrev
            && (st_reg.slotCfg[OUT0_SLOT_A_LSB +: 2] == SLOT_ZERO) |=> !pdmOut0;
    endproperty
    a_slot_zero: assert property (p_slot_zero)
        else $error("empty slot did not drive zero");

    property p_polarity;
        @(posedge clk) disable iff (!resetn)
        st_reg.bitClk && !st_reg.bitPrev && (st_reg.slotCfg[OUT0_SLOT_A_LSB +: 2] == SLOT_X)
            |=> pdmOut0 == ($past(pdmBits.x) ^ $past(st_reg.motionCtl[PDM_POLARITY_INVERT_BIT]));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("pdm bit polarity wrong");

    property p_hpf;
        @(posedge clk) disable iff (!resetn)
        sarValid && st_reg.motionCtl[HPF_EN_BIT] |=> detValid && (detSample == $past(hpfSample));
    endproperty
    a_hpf: assert property (p_hpf)
        else $error("filtered sample not routed to detectors");

    property p_indep_block;
        @(posedge clk) disable iff (!resetn)
        actHit && st_reg.status[IRQ_ACT_BIT]
            && ((st_reg.motionCtl[CHAIN_MODE_LSB +: 2] == CHAIN_INDEP)
            || (st_reg.motionCtl[CHAIN_MODE_LSB +: 2] == CHAIN_INDEP2)) |=> !actDetect;
    endproperty
    a_indep_block: assert property (p_indep_block)
        else $error("activity detected again before its flag cleared");

    property p_linked_block;
        @(posedge clk) disable iff (!resetn)
        (st_reg.motionCtl[CHAIN_MODE_LSB +: 2] == CHAIN_LINKED) && st_reg.status[IRQ_INACT_BIT]
            |=> !actDetect;
    endproperty
    a_linked_block: assert property (p_linked_block)
        else $error("linked activity detected while inactivity flag set");

    property p_act_gate;
        @(posedge clk) disable iff (!resetn)
        !det_on(st_reg.motionCtl[ACT_EN_LSB +: 2]) |=> !actClkEn && !actDetect;
    endproperty
    a_act_gate: assert property (p_act_gate)
        else $error("activity block clocked while disabled");

    property p_frame_ext;
        @(posedge clk) disable iff (!resetn)
        (st_reg.syncCfg[FRAME_CLK_SRC_LSB +: 2] == CLK_EXTERNAL)
            |=> frameClkOut == $past(st_reg.frameS2);
    endproperty
    a_frame_ext: assert property (p_frame_ext)
        else $error("external frame clock not followed");

    property p_sync_reserved;
        @(posedge clk) disable iff (!resetn)
        (st_reg.syncCfg[SYNC_MODE_LSB +: 2] == 2'h3) |=> !dsmLocked && !interpStrobe;
    endproperty
    a_sync_reserved: assert property (p_sync_reserved)
        else $error("reserved sync mode did not run free");

    property p_linked_inact;
        @(posedge clk) disable iff (!resetn)
        (st_reg.motionCtl[CHAIN_MODE_LSB +: 2] == CHAIN_LINKED) && st_reg.status[IRQ_ACT_BIT]
            |=> !inactDetect;
    endproperty
    a_linked_inact: assert property (p_linked_inact)
        else $error("linked inactivity detected while activity flag set");

    property p_looped_free;
        @(posedge clk) disable iff (!resetn)
        (st_reg.motionCtl[CHAIN_MODE_LSB +: 2] == CHAIN_LOOPED) && (st_reg.seq == WAIT_ACT)
            && actHit && det_on(st_reg.motionCtl[ACT_EN_LSB +: 2]) |=> actDetect;
    endproperty
    a_looped_free: assert property (p_looped_free)
        else $error("looped activity waited for a flag");

    property p_inact_off;
        @(posedge clk) disable iff (!resetn)
        !det_on(st_reg.motionCtl[INACTIVITY_DETECT_ENABLE_LSB +: 2]) |=> !inactDetect;
    endproperty
    a_inact_off: assert property (p_inact_off)
        else $error("inactivity detected while disabled");

    property p_irq_level;
        @(posedge clk) disable iff (!resetn)
        ##1 irq == |($past(st_next.status) & $past(st_next.mask));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt output disagrees with status and mask");

    c_looped: cover property (@(posedge clk) disable iff (!resetn)
        actDetect ##[1:1000] inactDetect);
    c_interp: cover property (@(posedge clk) disable iff (!resetn) interpStrobe);
    c_irq: cover property (@(posedge clk) disable iff (!resetn) $rose(irq));

endmodule : spac_config_bank

`default_nettype wire

// ### dv/spac_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// far side: makes the link bit clock and counts the clocks the block puts out
module spac_host_model (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic bitClkOut,
    input  wire logic frameClkOut,
    output var  logic extBitClk,
    output var  int   bitEdges,
    output var  int   frameEdges
);
    logic bitPrev;
    logic framePrev;

    // link clock stands low outside measuring windows
    initial extBitClk = 1'b0;
    always #200 extBitClk = run ? ~extBitClk : 1'b0;

    always @(posedge clk) begin
        bitPrev <= bitClkOut;
        framePrev <= frameClkOut;
        bitEdges <= !run ? 0 : bitEdges + int'(bitClkOut && !bitPrev);
        frameEdges <= !run ? 0 : frameEdges + int'(frameClkOut && !framePrev);
    end
endmodule : spac_host_model

`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench import spac_pkg::*;;
    logic                clk = 1'b0;
    logic                resetn = 1'b0;
    spac_bus_req_t       busReq = '0;
    spac_pdm_bits_t      pdmBits = '0;
    logic                framePinIn = 1'b0;
    logic                intOnePinIn = 1'b0;
    logic                sarValid = 1'b0;
    logic                actHit = 1'b0;
    logic                inactHit = 1'b0;
    logic                run = 1'b0;
    logic [SAMPLE_W-1:0] sarSample = 12'h123;
    logic [SAMPLE_W-1:0] hpfSample = 12'hABC;
    logic [SAMPLE_W-1:0] detSample;
    logic [7:0]          regRdata;
    logic                extBitClk, bitClkOut, frameClkOut, odrStrobe, interpStrobe;
    logic                dsmLocked, pdmFramePinOut, pdmOut0, detValid, actClkEn;
    logic                actDetect, inactDetect, irq;
    logic [1:0]          actMode, inactMode;
    int                  bitEdges, frameEdges;
    int                  fails = 0;
    int                  nChecks = 0;
    int                  cyc = 0;

    always #25 clk = ~clk;

    spac_config_bank i_dut (.clk(clk), .resetn(resetn), .busReq(busReq), .regRdata(regRdata),
        .framePinIn(framePinIn), .intOnePinIn(intOnePinIn), .extBitClkIn(extBitClk),
        .pdmBits(pdmBits), .sarValid(sarValid), .sarSample(sarSample), .hpfSample(hpfSample),
        .actHit(actHit), .inactHit(inactHit), .bitClkOut(bitClkOut), .frameClkOut(frameClkOut),
        .odrStrobe(odrStrobe), .interpStrobe(interpStrobe), .dsmLocked(dsmLocked),
        .pdmFramePinOut(pdmFramePinOut), .pdmOut0(pdmOut0), .detSample(detSample),
        .detValid(detValid), .actMode(actMode), .inactMode(inactMode), .actClkEn(actClkEn),
        .actDetect(actDetect), .inactDetect(inactDetect), .irq(irq));

    spac_host_model i_host (.clk(clk), .run(run), .bitClkOut(bitClkOut),
        .frameClkOut(frameClkOut), .extBitClk(extBitClk), .bitEdges(bitEdges),
        .frameEdges(frameEdges));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // clock counts are accepted within two edges either way
    task automatic chkr(input int got, input int exp);
        nChecks++;
        if (got < exp - 2 || got > exp + 2) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chkr

    task automatic results;
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic rst;
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask : rst

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 chk(regRdata, exp);
        @(posedge clk);
    endtask : rd

    task automatic hit(input logic a, input logic i, input logic ea, input logic ei);
        actHit <= a;
        inactHit <= i;
        @(posedge clk);
        actHit <= 1'b0;
        inactHit <= 1'b0;
        #1 chk({actDetect, inactDetect}, {ea, ei});
        @(posedge clk);
    endtask : hit

    task automatic waitBit(input logic v);
        for (int n = 0; n < 200 && bitClkOut !== v; n++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : waitBit

    task automatic t_regs;
        rd(ADDR_SYNC_CFG, RESET_CFG);
        rd(ADDR_SLOT_CFG, RESET_CFG);
        rd(ADDR_MOTION_CTL, RESET_CFG);
        wr(ADDR_SYNC_CFG, 8'hFF);
        rd(ADDR_SYNC_CFG, SYNC_CFG_WMASK);
        wr(ADDR_MOTION_CTL, 8'hC3);
        rd(ADDR_MOTION_CTL, 8'hC3);
        wr(8'h50, 8'hFF);
        rd(8'h50, 8'h00);
    endtask : t_regs

    task automatic t_clocks(input logic [7:0] cfg, input int eb, input int ef);
        wr(ADDR_SYNC_CFG, cfg);
        run <= 1'b1;
        repeat (10000) @(posedge clk);
        chkr(bitEdges, eb);
        chkr(frameEdges, ef);
        run <= 1'b0;
        @(posedge clk);
    endtask : t_clocks

    task automatic t_pdm(input logic [1:0] c, input logic pol);
        logic [2:0] b;
        b = (c == SLOT_ZERO) ? 3'b111 : 3'(3'b100 >> (c - 2'h1));
        wr(ADDR_SLOT_CFG, {~c, c, ~c, c});
        wr(ADDR_MOTION_CTL, {pol, 7'h00});
        pdmBits <= b;
        waitBit(1'b0);
        waitBit(1'b1);
        #1 chk({pdmOut0, pdmFramePinOut}, {2{(c == 2'h0) ? 1'b0 : b[3 - c] ^ pol}});
        waitBit(1'b0);
        #1 chk({pdmOut0, pdmFramePinOut}, {2{(c == 2'h3) ? 1'b0 : b[c] ^ pol}});
        @(posedge clk);
    endtask : t_pdm

    task automatic t_sync(input logic [7:0] cfg, input logic useInt, input logic [2:0] e);
        logic o;
        logic ip;
        o = 1'b0;
        ip = 1'b0;
        wr(ADDR_SYNC_CFG, cfg);
        if (useInt) intOnePinIn <= 1'b1;
        else framePinIn <= 1'b1;
        repeat (12) begin
            @(posedge clk);
            #1 o |= odrStrobe;
            ip |= interpStrobe;
        end
        chk({o, ip, dsmLocked}, e);
        @(posedge clk);
        framePinIn <= 1'b0;
        intOnePinIn <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : t_sync

    task automatic t_hpf(input logic [7:0] ctl, input logic [11:0] exp);
        wr(ADDR_MOTION_CTL, ctl);
        sarValid <= 1'b1;
        @(posedge clk);
        sarValid <= 1'b0;
        #1 chk({detValid, detSample}, {1'b1, exp});
        @(posedge clk);
    endtask : t_hpf

    task automatic t_indep;
        wr(ADDR_IRQ_MASK, 8'h03);
        wr(ADDR_MOTION_CTL, 8'h05);
        hit(1'b1, 1'b0, 1'b1, 1'b0);
        chk(irq, 1'b1);
        hit(1'b1, 1'b0, 1'b0, 1'b0);
        wr(ADDR_IRQ_STATUS, 8'h01);
        hit(1'b1, 1'b1, 1'b1, 1'b1);
        wr(ADDR_IRQ_STATUS, 8'h03);
        chk(irq, 1'b0);
        wr(ADDR_MOTION_CTL, 8'h2E);
        hit(1'b1, 1'b1, 1'b0, 1'b1);
        chk(actClkEn, 1'b0);
        chk({actMode, inactMode}, 4'hB);
    endtask : t_indep

    task automatic t_linked;
        rst();
        wr(ADDR_MOTION_CTL, 8'h0D);
        wr(ADDR_MOTION_CTL, 8'h1D);
        hit(1'b1, 1'b0, 1'b1, 1'b0);
        chk({irq, actClkEn}, 2'b01);
        wr(ADDR_IRQ_MASK, 8'h01);
        chk(irq, 1'b1);
        hit(1'b0, 1'b1, 1'b0, 1'b0);
        wr(ADDR_IRQ_STATUS, 8'h01);
        hit(1'b0, 1'b1, 1'b0, 1'b1);
    endtask : t_linked

    task automatic t_looped;
        rst();
        wr(ADDR_MOTION_CTL, 8'h0D);
        wr(ADDR_MOTION_CTL, 8'h3D);
        hit(1'b0, 1'b1, 1'b0, 1'b0);
        hit(1'b1, 1'b0, 1'b1, 1'b0);
        hit(1'b1, 1'b0, 1'b0, 1'b0);
        hit(1'b0, 1'b1, 1'b0, 1'b1);
        hit(1'b1, 1'b0, 1'b1, 1'b0);
    endtask : t_looped

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fails++;
            results();
        end
    end

    initial begin
        rst();
        t_regs();
        rst();
        t_clocks(8'h00, 1250, 0);
        t_clocks(8'h05, int'(BIT_CLK_FAST_KHZ / 2), int'(FRAME_CLK_SLOW_KHZ / 2));
        t_clocks(8'h0A, int'(BIT_CLK_SLOW_KHZ / 2), int'(FRAME_CLK_FAST_KHZ / 2));
        t_clocks(8'h0F, 1250, 0);
        wr(ADDR_SYNC_CFG, 8'h04);
        for (int c = 0; c < 4; c++) begin
            t_pdm(2'(c), 1'b0);
            t_pdm(2'(c), 1'b1);
        end
        t_sync(8'h10, 1'b0, 3'b101);
        t_sync(8'h50, 1'b1, 3'b101);
        t_sync(8'h50, 1'b0, 3'b001);
        t_sync(8'h20, 1'b0, 3'b110);
        t_sync(8'h30, 1'b0, 3'b100);
        t_hpf(8'h00, 12'h123);
        t_hpf(8'h40, 12'hABC);
        t_indep();
        t_linked();
        t_looped();
        results();
    end
endmodule : testbench

`default_nettype wire
